/* include/mpu_access_control_map.svh */
`ifndef MPU_ACCESS_CONTROL_MAP_SVH
`define MPU_ACCESS_CONTROL_MAP_SVH

// Register byte offsets
`define OFS_CTRL            8'h00
`define OFS_REGION_SEL      8'h04
`define OFS_REGION_BASE     8'h08
`define OFS_REGION_ATTR     8'h0c
`define OFS_STATUS          8'h10
`define OFS_MASK            8'h14
`define OFS_FAULT_ADDR      8'h18

// Region table geometry
`define REGION_COUNT        8
`define REGION_IDX_W        3
`define BASE_LSB            5

// Protection control fields
`define CTRL_W              3
`define CTRL_ENABLE_BIT     0
`define CTRL_HANDLER_BIT    1
`define CTRL_BACKGROUND_BIT 2
`define CTRL_RESET          3'h0

// Region attribute fields
`define ATTR_EN_BIT         0
`define ATTR_SIZE_LSB       1
`define ATTR_SIZE_MSB       5
`define ATTR_UNPRIV_BIT     8
`define ATTR_WRITE_BIT      9
`define SIZE_RESET          5'h04

// Status and mask fields
`define STAT_W              2
`define STAT_FAULT_BIT      0
`define STAT_NOREGION_BIT   1
`define STAT_RESET          2'h0
`define MASK_RESET          2'h0

`endif

/* include/mpu_access_control_pkg.sv */
package mpu_access_control_pkg;
`include "mpu_access_control_map.svh"

   typedef struct packed {
      logic [31:`BASE_LSB] base;
      logic [4:0]          size;
      logic                en;
      logic                unpriv_ok;
      logic                write_ok;
   } region_t;

   typedef logic [`REGION_IDX_W-1:0] region_idx_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;

endpackage : mpu_access_control_pkg

/* include/region_check_if.sv */
`timescale 1ns/100ps
`include "mpu_access_control_map.svh"
interface region_check_if;
   import mpu_access_control_pkg::*;

   logic [31:0] addr;
   region_t     table_q [`REGION_COUNT];
   logic        hit;
   region_idx_t hit_idx;
   region_t     hit_region;

   modport requester (output addr, output table_q, input hit, input hit_idx, input hit_region);
   modport matcher   (input addr, input table_q, output hit, output hit_idx, output hit_region);
endinterface : region_check_if

/* logic/region_matcher.sv */
`timescale 1ns/100ps
`include "mpu_access_control_map.svh"
module region_matcher
   import mpu_access_control_pkg::*;
(
   region_check_if.matcher ck
);

   // Region covers 2^(size+1) bytes, 32 at least: only address bits above size take part
   function automatic logic covers(input logic [31:0] addr, input region_t r);
      logic match;
      match = r.en;
      for (int i = `BASE_LSB; i < 32; i++) begin
         if ((i > int'(r.size)) && (addr[i] != r.base[i])) begin
            match = 1'b0;
         end
      end
      return match;
   endfunction : covers

   // Highest numbered enabled region wins on overlap
   always_comb begin
      ck.hit        = 1'b0;
      ck.hit_idx    = '0;
      ck.hit_region = '0;
      for (int i = 0; i < `REGION_COUNT; i++) begin
         if (covers(ck.addr, ck.table_q[i])) begin
            ck.hit        = 1'b1;
            ck.hit_idx    = region_idx_t'(i);
            ck.hit_region = ck.table_q[i];
         end
      end
   end

endmodule : region_matcher

/* logic/mpu_access_control.sv */
// Functional notes
// - Control bit 0 switches all access checking on or off.
// - Enabled, background off: address outside every enabled region faults.
// - Enabled, background on: default map backs privileged accesses only.
// - Any matching enabled region overrides the background map.
// - Background enable is ignored while protection is off.
// - Handler enable 0: no checking inside escalated handlers.
// - Handler enable 1 with protection on: handlers are checked too.
// - Both enables set: unprivileged access missing all regions faults.
// - Both enables set: privileged access missing regions uses default map.
// - Region size in bytes is two to the power size plus one.
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "mpu_access_control_map.svh"
module mpu_access_control
   import mpu_access_control_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        acc_valid,
   input  wire logic [31:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic        acc_privileged,
   input  wire logic        acc_escalated,
   output logic             acc_done,
   output logic             acc_fault,
   output logic             acc_region_hit,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   bus_state_t          bus_state;
   bus_state_t          next_bus_state;
   logic [`CTRL_W-1:0]  ctrl;
   logic [`CTRL_W-1:0]  next_ctrl;
   region_idx_t         region_sel;
   region_idx_t         next_region_sel;
   region_t             regions      [`REGION_COUNT];
   region_t             next_regions [`REGION_COUNT];
   logic [`STAT_W-1:0]  status;
   logic [`STAT_W-1:0]  next_status;
   logic [`STAT_W-1:0]  mask;
   logic [`STAT_W-1:0]  next_mask;
   logic [31:0]         fault_addr;
   logic [31:0]         next_fault_addr;
   logic [31:0]         next_readdata;
   logic                next_waitrequest;
   logic                next_irq;
   logic                next_done;
   logic                next_fault;
   logic                next_region_hit;

   logic                bus_accept;
   logic                bus_commit;
   logic [31:0]         merged;
   logic                checking;
   logic                deny;
   logic                no_region;
   logic [`STAT_W-1:0]  set_evt;

   region_check_if ck ();

   region_matcher u_region_matcher (
      .ck (ck.matcher)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   function automatic logic [31:0] attr_word(input region_t r);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`ATTR_EN_BIT]                  = r.en;
      w[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB] = r.size;
      w[`ATTR_UNPRIV_BIT]              = r.unpriv_ok;
      w[`ATTR_WRITE_BIT]               = r.write_ok;
      return w;
   endfunction : attr_word

   ////////////////////////////////////////////////////////////////////////////
   // Access check

   assign ck.addr = acc_addr;

   always_comb begin
      for (int i = 0; i < `REGION_COUNT; i++) begin
         ck.table_q[i] = regions[i];
      end
   end

   // Escalated handlers bypass checking unless the handler enable is set
   assign checking = ctrl[`CTRL_ENABLE_BIT] &&
                     (!acc_escalated || ctrl[`CTRL_HANDLER_BIT]);

   always_comb begin
      deny      = 1'b0;
      no_region = 1'b0;
      if (checking) begin
         if (ck.hit) begin
            // A matching region decides alone, even against the background map
            deny = (!acc_privileged && !ck.hit_region.unpriv_ok) ||
                   (acc_write && !ck.hit_region.write_ok);
         end else if (ctrl[`CTRL_BACKGROUND_BIT] && acc_privileged) begin
            deny = 1'b0;
         end else begin
            deny      = 1'b1;
            no_region = 1'b1;
         end
      end
   end

   // Background bit is only read inside the checking path above
   always_comb begin
      next_done       = acc_valid;
      next_fault      = acc_valid && deny;
      next_region_hit = acc_valid && checking && ck.hit;
      set_evt         = '0;
      if (acc_valid && deny) begin
         set_evt[`STAT_FAULT_BIT]    = 1'b1;
         set_evt[`STAT_NOREGION_BIT] = no_region;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_done       <= 1'b0;
         acc_fault      <= 1'b0;
         acc_region_hit <= 1'b0;
      end else begin
         acc_done       <= next_done;
         acc_fault      <= next_fault;
         acc_region_hit <= next_region_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave handshake: one wait cycle per transfer

   assign bus_accept = (avs_read || avs_write) && (bus_state == BUS_IDLE);
   assign bus_commit = avs_write && (bus_state == BUS_ACK);
   // A request still high in the acknowledge cycle is never taken a second time

   always_comb begin
      case (bus_state)
         BUS_IDLE: begin
            next_bus_state = bus_accept ? BUS_ACK : BUS_IDLE;
         end
         BUS_ACK: begin
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
      next_waitrequest = (next_bus_state != BUS_ACK);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state       <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         bus_state       <= next_bus_state;
         avs_waitrequest <= next_waitrequest;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   always_comb begin
      next_ctrl       = ctrl;
      next_region_sel = region_sel;
      next_mask       = mask;
      next_fault_addr = fault_addr;
      next_readdata   = avs_readdata;
      for (int i = 0; i < `REGION_COUNT; i++) begin
         next_regions[i] = regions[i];
      end
      merged = 32'h0000_0000;

      if (bus_commit) begin
         case (avs_address)
            `OFS_CTRL: begin
               merged    = merge_bytes({29'h0, ctrl}, avs_writedata, avs_byteenable);
               next_ctrl = merged[`CTRL_W-1:0];
            end
            `OFS_REGION_SEL: begin
               merged          = merge_bytes({29'h0, region_sel}, avs_writedata,
                                             avs_byteenable);
               next_region_sel = merged[`REGION_IDX_W-1:0];
            end
            `OFS_REGION_BASE: begin
               merged = merge_bytes({regions[region_sel].base, 5'h00}, avs_writedata,
                                    avs_byteenable);
               next_regions[region_sel].base = merged[31:`BASE_LSB];
            end
            `OFS_REGION_ATTR: begin
               merged = merge_bytes(attr_word(regions[region_sel]), avs_writedata,
                                    avs_byteenable);
               next_regions[region_sel].en        = merged[`ATTR_EN_BIT];
               // Size below 4 is not trapped; the matcher treats it as 32 bytes
               next_regions[region_sel].size      =
                  merged[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB];
               next_regions[region_sel].unpriv_ok = merged[`ATTR_UNPRIV_BIT];
               next_regions[region_sel].write_ok  = merged[`ATTR_WRITE_BIT];
            end
            `OFS_MASK: begin
               merged    = merge_bytes({30'h0, mask}, avs_writedata, avs_byteenable);
               next_mask = merged[`STAT_W-1:0];
            end
            default: begin
               merged = 32'h0000_0000;
            end
         endcase
      end

      if (acc_valid && deny) begin
         next_fault_addr = acc_addr;
      end

      if (bus_accept && avs_read) begin
         case (avs_address)
            `OFS_CTRL:        next_readdata = {29'h0, ctrl};
            `OFS_REGION_SEL:  next_readdata = {29'h0, region_sel};
            `OFS_REGION_BASE: next_readdata = {regions[region_sel].base, 5'h00};
            `OFS_REGION_ATTR: next_readdata = attr_word(regions[region_sel]);
            `OFS_STATUS:      next_readdata = {30'h0, status};
            `OFS_MASK:        next_readdata = {30'h0, mask};
            `OFS_FAULT_ADDR:  next_readdata = fault_addr;
            default:          next_readdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats a same-cycle clear

   always_comb begin
      logic [`STAT_W-1:0] clr;
      clr = '0;
      if (bus_commit && (avs_address == `OFS_STATUS)) begin
         clr = avs_writedata[`STAT_W-1:0] & {`STAT_W{avs_byteenable[0]}};
      end
      next_status = (status & ~clr) | set_evt;
      next_irq    = |(next_status & next_mask);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl         <= `CTRL_RESET;
         region_sel   <= '0;
         status       <= `STAT_RESET;
         mask         <= `MASK_RESET;
         fault_addr   <= 32'h0000_0000;
         avs_readdata <= 32'h0000_0000;
         irq          <= 1'b0;
         for (int i = 0; i < `REGION_COUNT; i++) begin
            regions[i] <= '{base: '0, size: `SIZE_RESET, en: 1'b0,
                            unpriv_ok: 1'b0, write_ok: 1'b0};
         end
      end else begin
         ctrl         <= next_ctrl;
         region_sel   <= next_region_sel;
         status       <= next_status;
         mask         <= next_mask;
         fault_addr   <= next_fault_addr;
         avs_readdata <= next_readdata;
         irq          <= next_irq;
         for (int i = 0; i < `REGION_COUNT; i++) begin
            regions[i] <= next_regions[i];
         end
      end
   end

endmodule : mpu_access_control

/* tb/mpu_access_control_properties.sv */
`timescale 1ns/100ps
module mpu_access_control_properties (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        acc_valid,
   input wire logic        acc_privileged,
   input wire logic        acc_escalated,
   input wire logic        acc_done,
   input wire logic        acc_fault,
   input wire logic        acc_region_hit
);
   logic [2:0] ctrl_seen;
   logic [2:0] next_ctrl_seen;
   logic       active;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the control bits, taken only at the accepting edge of a write
   always_comb begin
      next_ctrl_seen = ctrl_seen;
      if (avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0]) begin
         next_ctrl_seen = avs_writedata[2:0];
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_seen <= 3'h0;
      end else begin
         ctrl_seen <= next_ctrl_seen;
      end
   end
   assign active = ctrl_seen[0] && (!acc_escalated || ctrl_seen[1]);
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_DONE_LATENCY: assert property (acc_valid |=> acc_done)
      else $error("no completion one cycle after an access");
   AST_DONE_CAUSE: assert property (acc_done |-> $past(acc_valid))
      else $error("completion without an access");
   AST_FLAGS_WITH_DONE: assert property ((acc_fault || acc_region_hit) |-> acc_done)
      else $error("fault or hit outside a completion");
   AST_OFF_ALLOWS: assert property (
      acc_valid && !ctrl_seen[0] |=> !acc_fault && !acc_region_hit)
      else $error("checking while protection is off");
   AST_BG_IGNORED: assert property (acc_valid && ctrl_seen == 3'h4 |=> !acc_fault)
      else $error("background bit acted while protection is off");
   AST_HANDLER_SKIP: assert property (
      acc_valid && acc_escalated && !ctrl_seen[1] |=> !acc_fault)
      else $error("escalated access checked with handler enable clear");
   AST_HANDLER_CHECK: assert property (
      acc_valid && acc_escalated && ctrl_seen == 3'h3 |=> acc_region_hit || acc_fault)
      else $error("escalated miss allowed with handler enable set");
   AST_MISS_FAULTS: assert property (
      acc_valid && active && !ctrl_seen[2] |=> acc_region_hit || acc_fault)
      else $error("miss allowed without background map");
   AST_UNPRIV_MISS: assert property (
      acc_valid && active && !acc_privileged |=> acc_region_hit || acc_fault)
      else $error("unprivileged miss allowed");
   AST_PRIV_BACKGROUND: assert property (
      acc_valid && active && ctrl_seen[2] && acc_privileged |=> acc_region_hit || !acc_fault)
      else $error("privileged miss faulted with background map on");
   AST_CTRL_RESERVED: assert property (
      avs_read && !avs_waitrequest && avs_address == 8'h00 |-> avs_readdata[31:3] == 29'h0)
      else $error("reserved control bits read nonzero");
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not exactly one wait cycle");
   cover property (acc_valid ##1 acc_fault);
   cover property (acc_valid && acc_escalated && ctrl_seen[1]);
   cover property (acc_valid && ctrl_seen[2] && acc_privileged ##1 !acc_region_hit);
endmodule : mpu_access_control_properties

bind mpu_access_control mpu_access_control_properties u_props (
   .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
   .acc_privileged(acc_privileged), .acc_escalated(acc_escalated), .acc_done(acc_done),
   .acc_fault(acc_fault), .acc_region_hit(acc_region_hit));

/* tb/core_port.sv */
`timescale 1ns/100ps
module core_port (
   input  wire logic        core_clk,
   output logic             acc_valid,
   output logic [31:0]      acc_addr,
   output logic             acc_write,
   output logic             acc_privileged,
   output logic             acc_escalated,
   input  wire logic        acc_done,
   input  wire logic        acc_fault,
   input  wire logic        acc_region_hit
);
   initial begin
      acc_valid = 1'b0;
      acc_addr = 32'h0;
      {acc_write, acc_privileged, acc_escalated} = 3'h0;
   end
   // One-cycle request; result is read mid-cycle so no edge race
   task automatic access(input logic [31:0] a, input logic [2:0] wpe, output logic [2:0] dfh);
      @(posedge core_clk);
      acc_valid <= 1'b1;
      acc_addr <= a;
      {acc_write, acc_privileged, acc_escalated} <= wpe;
      @(posedge core_clk);
      acc_valid <= 1'b0;
      // Stale qualifiers must not look valid, so show their inverse
      acc_addr <= ~a;
      {acc_write, acc_privileged, acc_escalated} <= ~wpe;
      @(negedge core_clk);
      dfh = {acc_done, acc_fault, acc_region_hit};
   endtask : access
endmodule : core_port

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import mpu_access_control_pkg::*;
   logic        core_clk;
   logic        rst_n;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        acc_valid;
   logic [31:0] acc_addr;
   logic        acc_write;
   logic        acc_privileged;
   logic        acc_escalated;
   logic        acc_done;
   logic        acc_fault;
   logic        acc_region_hit;
   logic        irq;
   logic [2:0]  ctrl_cur;
   logic [31:0] last_fault;
   logic [31:0] q;
   int          fail_count;
   int          samples_checked;

   mpu_access_control DUT (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
      .acc_privileged(acc_privileged), .acc_escalated(acc_escalated), .acc_done(acc_done),
      .acc_fault(acc_fault), .acc_region_hit(acc_region_hit), .irq(irq));
   core_port core (.core_clk(core_clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
      .acc_write(acc_write), .acc_privileged(acc_privileged), .acc_escalated(acc_escalated),
      .acc_done(acc_done), .acc_fault(acc_fault), .acc_region_hit(acc_region_hit));

   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge core_clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      // No local limit: only the watchdog may end a hung handshake
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   // Handler enable is never set without the main enable
   task automatic run(input logic [2:0] c, input logic [31:0] a, input logic [2:0] wpe,
                      input logic [1:0] fh);
      logic [2:0]  r;
      logic [31:0] tmp;
      if (c !== ctrl_cur) begin
         bus(1'b1, 8'h00, {29'h0, c}, tmp);
         ctrl_cur = c;
      end
      core.access(a, wpe, r);
      check("access", {29'h0, r}, {29'h0, 1'b1, fh});
      if (fh[1]) last_fault = a;
   endtask : run

   task automatic irq_is(input logic e);
      repeat (2) @(negedge core_clk);
      check("irq", {31'h0, irq}, {31'h0, e});
   endtask : irq_is
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      wrap_up();
   end

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      {avs_address, avs_read, avs_write, avs_writedata} = 42'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h00, 32'h0, q);
      check("ctrl", q, 32'h0);
      bus(1'b1, 8'h00, 32'hffff_fff9, q);
      bus(1'b0, 8'h00, 32'h0, q);
      check("ctrl", q, 32'h1);
      ctrl_cur = 3'h1;
      // Region 0: 1 KB read-only, region 1: 32 B read-write inside it
      bus(1'b1, 8'h04, 32'h0, q);
      bus(1'b1, 8'h08, 32'h2000_0000, q);
      bus(1'b1, 8'h0c, 32'h0000_0113, q);
      bus(1'b1, 8'h04, 32'h1, q);
      bus(1'b1, 8'h08, 32'h2000_0100, q);
      bus(1'b1, 8'h0c, 32'h0000_0309, q);
      run(3'h0, 32'h4000_0000, 3'b000, 2'b00);
      run(3'h4, 32'h4000_0000, 3'b000, 2'b00);
      run(3'h1, 32'h4000_0000, 3'b010, 2'b10);
      run(3'h1, 32'h2000_0004, 3'b000, 2'b01);
      run(3'h1, 32'h2000_0004, 3'b100, 2'b11);
      run(3'h1, 32'h2000_0104, 3'b100, 2'b01);
      run(3'h1, 32'h2000_0120, 3'b100, 2'b11);
      run(3'h1, 32'h2000_03fc, 3'b000, 2'b01);
      run(3'h1, 32'h2000_0400, 3'b010, 2'b10);
      run(3'h1, 32'h4000_0000, 3'b011, 2'b00);
      run(3'h3, 32'h4000_0000, 3'b011, 2'b10);
      run(3'h3, 32'h2000_0004, 3'b001, 2'b01);
      run(3'h5, 32'h4000_0000, 3'b010, 2'b00);
      run(3'h5, 32'h4000_0000, 3'b000, 2'b10);
      run(3'h5, 32'h2000_0004, 3'b110, 2'b11);
      run(3'h5, 32'h4000_0000, 3'b001, 2'b00);
      irq_is(1'b0);
      bus(1'b0, 8'h10, 32'h0, q);
      check("status", q, 32'h3);
      bus(1'b0, 8'h18, 32'h0, q);
      check("fault_addr", q, last_fault);
      bus(1'b1, 8'h14, 32'h3, q);
      irq_is(1'b1);
      bus(1'b1, 8'h10, 32'h1, q);
      irq_is(1'b1);
      bus(1'b0, 8'h10, 32'h0, q);
      check("status", q, 32'h2);
      bus(1'b1, 8'h10, 32'h2, q);
      irq_is(1'b0);
      bus(1'b0, 8'hfc, 32'h0, q);
      check("unmapped", q, 32'h0);
      wrap_up();
   end
endmodule : testbench
